// ==== shared/rtp_pkg.sv ====
// Constants, register map and types for the reload timers block
package rtp_pkg;
	localparam int NUM_TIMERS = 3;
	localparam int CNT_W      = 8;
	localparam int PS_W       = 3;
	localparam int ADDR_W     = 12;
	localparam int IDX_W      = 8;
	localparam int DATA_W     = 32;

	// Register indices; byte address is four times the index
	localparam logic [IDX_W-1:0] IDX_WATCH_CTRL = 8'h21;
	localparam logic [IDX_W-1:0] IDX_CTRL_BASE  = 8'h10;
	localparam logic [IDX_W-1:0] IDX_LATCH_BASE = 8'h14;
	localparam logic [IDX_W-1:0] IDX_COUNT_BASE = 8'h18;
	localparam logic [IDX_W-1:0] IDX_PWM_CTRL   = 8'h1c;
	localparam logic [IDX_W-1:0] IDX_INT_STATUS = 8'h1d;
	localparam logic [IDX_W-1:0] IDX_INT_ENABLE = 8'h1e;
	localparam logic [IDX_W-1:0] IDX_INT_CLEAR  = 8'h1f;

	// Timer control fields
	localparam int CTRL_RUN_BIT  = 0;
	localparam int CTRL_SRC_LSB  = 1;
	localparam int CTRL_EDGE_BIT = 3;
	localparam int CTRL_PS_LSB   = 4;
	localparam int CTRL_LOAD_BIT = 7;
	localparam logic [7:0] CTRL_RESET = 8'h00;

	// Watch control fields; bits 7 and 3 read as zero
	localparam int WCTL_EXT_BIT = 4;
	localparam logic [7:0] WCTL_MASK  = 8'h77;
	localparam logic [7:0] WCTL_RESET = 8'h00;

	// PWM control: enable and 2-bit interrupt rate
	localparam int PWMC_EN_BIT   = 0;
	localparam int PWMC_RATE_LSB = 1;
	localparam logic [2:0] PWMC_MASK = 3'h7;

	// Interrupt bit positions
	localparam int INT_PERIOD = 0;
	localparam int INT_DUTY   = 1;
	localparam int INT_THIRD  = 2;
	localparam int INT_W      = 3;

	// Instruction tick as oscillator ticks minus one
	localparam logic [1:0] INSTR_LIM_DIV2 = 2'h1;
	localparam logic [1:0] INSTR_LIM_DIV4 = 2'h3;

	typedef enum logic [1:0] {
		RTP_SRC_EVENT = 2'h0,
		RTP_SRC_INSTR = 2'h1,
		RTP_SRC_OSC   = 2'h2,
		RTP_SRC_OSC2  = 2'h3
	} rtp_src_t;

	typedef enum logic [1:0] {
		RTP_PWM_IDLE = 2'b00,
		RTP_PWM_HIGH = 2'b01,
		RTP_PWM_LOW  = 2'b11
	} rtp_pwm_state_t;
endpackage

// ==== verilog/rtp_timer_chan.sv ====
// One down-counting auto-reload timer with 3-bit prescaler
`timescale 1ns/1ns
module rtp_timer_chan #(
	parameter int WIDTH = 8,
	parameter int PSW   = 3
) (
	// Clock and reset
	input  wire logic             pclk,
	input  wire logic             presetn,
	// Control
	input  wire logic             tick,
	input  wire logic             run,
	input  wire logic [PSW-1:0]   prescale,
	input  wire logic [WIDTH-1:0] preset,
	input  wire logic             load_now,
	input  wire logic [WIDTH-1:0] load_value,
	input  wire logic             restart,
	// Status
	output logic [WIDTH-1:0]      count,
	output logic                  underflow
);
	localparam int PCW = (1 << PSW) - 1;

	logic [PCW-1:0]   presc_reg;
	logic [PCW-1:0]   presc_next;
	logic [WIDTH-1:0] count_reg;
	logic [WIDTH-1:0] count_next;
	wire  [PCW-1:0]   presc_limit;
	wire              fire;

	// divide by two to the code
	assign presc_limit = {PCW{1'b1}} >> (PCW - int'(prescale));
	assign fire      = run & tick & (presc_reg == presc_limit);
	assign underflow = fire & (count_reg == '0);
	assign count     = count_reg;

	always_comb begin
		presc_next = presc_reg;
		if (!run || restart) begin
			presc_next = '0;
		end else if (tick) begin
			presc_next = fire ? '0 : presc_reg + 1'b1;
		end
	end

	always_comb begin
		count_next = count_reg;
		if (load_now) begin
			count_next = load_value;
		end else if (restart) begin
			count_next = preset;
		end else if (fire) begin
			count_next = underflow ? preset : count_reg - 1'b1;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			presc_reg <= '0;
			count_reg <= '0;
		end else begin
			presc_reg <= presc_next;
			count_reg <= count_next;
		end
	end

	chk_reload_value: assert property (@(posedge pclk) disable iff (!presetn)
		underflow && !load_now && !restart |=> count_reg == $past(preset))
		else $error("timer did not reload preset after zero");
	chk_run_hold: assert property (@(posedge pclk) disable iff (!presetn)
		!run && !load_now && !restart |=> $stable(count_reg))
		else $error("stopped timer changed its count");
	chk_autoload_now: assert property (@(posedge pclk) disable iff (!presetn)
		load_now |=> count_reg == $past(load_value))
		else $error("latch write not moved into counter");
endmodule

// ==== verilog/rtp_reload_timers.sv ====
// Three reload timers with PWM, APB registers and interrupt
`timescale 1ns/1ns
module rtp_reload_timers #(
	parameter int N_TIMERS = rtp_pkg::NUM_TIMERS
) (
	// Clock and reset
	input  wire logic                       pclk,
	input  wire logic                       presetn,
	// APB slave
	input  wire logic                       psel,
	input  wire logic                       penable,
	input  wire logic                       pwrite,
	input  wire logic [rtp_pkg::ADDR_W-1:0] paddr,
	input  wire logic [rtp_pkg::DATA_W-1:0] pwdata,
	output logic                            pready,
	output logic [rtp_pkg::DATA_W-1:0]      prdata,
	output logic                            pslverr,
	// Pins and configuration word
	input  wire logic                       shared_port_pin,
	input  wire logic                       osc_instr_div2,
	output logic                            shared_pin_io,
	output logic                            pulse_output,
	output logic                            irq
);
	import rtp_pkg::*;

	logic [7:0]         ctrl_reg [N_TIMERS];
	logic [CNT_W-1:0]   latch_reg [N_TIMERS];
	logic [7:0]         watch_ctrl_reg;
	logic [2:0]         pwm_ctrl_reg;
	logic [INT_W-1:0]   int_status_reg;
	logic [INT_W-1:0]   int_status_next;
	logic [INT_W-1:0]   int_enable_reg;
	logic [DATA_W-1:0]  prdata_reg;
	logic               pready_reg;
	logic               pslverr_reg;
	logic               pin_prev_reg;
	logic               osc_div_reg;
	logic [1:0]         instr_cnt_reg;
	logic [2:0]         pulse_cnt_reg;
	logic [2:0]         pulse_cnt_next;
	rtp_pwm_state_t     pwm_state_reg;
	rtp_pwm_state_t     pwm_state_next;
	logic               pulse_output_reg;
	logic               irq_reg;
	logic               shared_pin_io_reg;

	// Address decode
	wire              setup   = psel & ~penable;
	wire              acc_wr  = psel & penable & pready_reg & pwrite;
	wire [IDX_W-1:0]  idx     = paddr[IDX_W+1:2];
	wire              addr_ok = (paddr[1:0] == 2'h0) & (paddr[ADDR_W-1:IDX_W+2] == '0);
	wire              hit_watch = addr_ok & (idx == IDX_WATCH_CTRL);
	wire              hit_pwm   = addr_ok & (idx == IDX_PWM_CTRL);
	wire              hit_stat  = addr_ok & (idx == IDX_INT_STATUS);
	wire              hit_en    = addr_ok & (idx == IDX_INT_ENABLE);
	wire              hit_clr   = addr_ok & (idx == IDX_INT_CLEAR);
	wire [N_TIMERS-1:0] hit_ctrl;
	wire [N_TIMERS-1:0] hit_latch;
	wire [N_TIMERS-1:0] hit_cnt;
	wire [N_TIMERS-1:0] tick;
	wire [N_TIMERS-1:0] uf;
	wire [N_TIMERS-1:0] load_now;
	wire [N_TIMERS-1:0] restart;
	wire [7:0]          rd_timer [N_TIMERS];
	wire [7:0]          rd_or    [N_TIMERS+1];
	wire [CNT_W-1:0]    cnt      [N_TIMERS];

	// pin is event clock only when selected
	wire ext_sel = watch_ctrl_reg[WCTL_EXT_BIT];
	// edge detection on the event pin
	wire ev_rise = ext_sel & shared_port_pin & ~pin_prev_reg;
	wire ev_fall = ext_sel & ~shared_port_pin & pin_prev_reg;

	// oscillator ticks every second pclk; pclk is the doubled rate
	wire        osc_tick   = osc_div_reg;
	wire [1:0]  instr_lim  = osc_instr_div2 ? INSTR_LIM_DIV2 : INSTR_LIM_DIV4;
	// instruction cycle from configured oscillator ratio
	wire        instr_tick = osc_tick & (instr_cnt_reg == instr_lim);

	assign rd_or[0] = 8'h00;

	genvar gi;
	generate
		for (gi = 0; gi < N_TIMERS; gi++) begin : g_tmr
			wire [1:0] src  = ctrl_reg[gi][CTRL_SRC_LSB+1:CTRL_SRC_LSB];
			wire       edge_fall = ctrl_reg[gi][CTRL_EDGE_BIT];
			wire       ev_tick   = edge_fall ? ev_fall : ev_rise;
			wire       osc2_ok   = (gi != N_TIMERS - 1);
			wire       latch_wr;

			assign hit_ctrl[gi]  = addr_ok & (idx == IDX_W'(IDX_CTRL_BASE + gi));
			assign hit_latch[gi] = addr_ok & (idx == IDX_W'(IDX_LATCH_BASE + gi));
			assign hit_cnt[gi]   = addr_ok & (idx == IDX_W'(IDX_COUNT_BASE + gi));
			assign latch_wr      = acc_wr & hit_latch[gi];
			// write with autoload goes straight to counter
			assign load_now[gi]  = latch_wr & ctrl_reg[gi][CTRL_LOAD_BIT];

			// source select; no doubled clock on third timer
			assign tick[gi] = (src == RTP_SRC_EVENT) ? ev_tick :
			                  (src == RTP_SRC_INSTR) ? instr_tick :
			                  (src == RTP_SRC_OSC)   ? osc_tick :
			                  osc2_ok;

			assign rd_timer[gi] = ({8{hit_ctrl[gi]}} & ctrl_reg[gi]) |
			                      ({8{hit_latch[gi]}} & latch_reg[gi]) |
			                      ({8{hit_cnt[gi]}} & cnt[gi]);
			assign rd_or[gi+1]  = rd_or[gi] | rd_timer[gi];

			always_ff @(posedge pclk or negedge presetn) begin
				if (!presetn) begin
					ctrl_reg[gi]  <= CTRL_RESET;
					latch_reg[gi] <= '0;
				end else begin
					if (acc_wr && hit_ctrl[gi]) begin
						ctrl_reg[gi] <= pwdata[7:0];
					end
					if (latch_wr) begin
						latch_reg[gi] <= pwdata[CNT_W-1:0];
					end
				end
			end

			rtp_timer_chan #(
				.WIDTH (CNT_W),
				.PSW   (PS_W)
			) u_chan (
				.pclk       (pclk),
				.presetn    (presetn),
				.tick       (tick[gi]),
				.run        (ctrl_reg[gi][CTRL_RUN_BIT]),
				.prescale   (ctrl_reg[gi][CTRL_PS_LSB+PS_W-1:CTRL_PS_LSB]),
				.preset     (latch_reg[gi]),
				.load_now   (load_now[gi]),
				.load_value (pwdata[CNT_W-1:0]),
				.restart    (restart[gi]),
				.count      (cnt[gi]),
				.underflow  (uf[gi])
			);
		end
	endgenerate

	// period timer run bit starts PWM
	wire pwm_mode  = pwm_ctrl_reg[PWMC_EN_BIT] & ctrl_reg[0][CTRL_RUN_BIT];
	wire pwm_start = pwm_mode & (pwm_state_reg == RTP_PWM_IDLE);
	wire [1:0] rate = pwm_ctrl_reg[PWMC_RATE_LSB+1:PWMC_RATE_LSB];
	wire [2:0] rate_lim = 3'h7 >> (2'h3 - rate);
	wire pwm_evt = pwm_mode & uf[0] & (pulse_cnt_reg == rate_lim);

	// duty restarts with every period reload
	assign restart[0] = pwm_start;
	assign restart[1] = pwm_start | (pwm_mode & uf[0]);
	assign restart[2] = 1'b0;

	always_comb begin
		pwm_state_next = pwm_state_reg;
		if (!pwm_mode) begin
			pwm_state_next = RTP_PWM_IDLE;
		end else begin
			case (pwm_state_reg)
				RTP_PWM_IDLE: pwm_state_next = RTP_PWM_HIGH;
				// period wins over duty in the same cycle
				RTP_PWM_HIGH: begin
					if (!uf[0] && uf[1]) begin
						pwm_state_next = RTP_PWM_LOW;
					end
				end
				RTP_PWM_LOW: begin
					if (uf[0]) begin
						pwm_state_next = RTP_PWM_HIGH;
					end
				end
				default: pwm_state_next = RTP_PWM_IDLE;
			endcase
		end
	end

	always_comb begin
		pulse_cnt_next = pulse_cnt_reg;
		if (!pwm_mode) begin
			pulse_cnt_next = '0;
		end else if (uf[0]) begin
			pulse_cnt_next = pwm_evt ? 3'h0 : pulse_cnt_reg + 3'h1;
		end
	end

	// Interrupt flags; a set in the clear cycle wins
	wire [INT_W-1:0] clr_bits = (acc_wr && hit_clr) ? pwdata[INT_W-1:0] : '0;
	wire [INT_W-1:0] set_bits;
	// period flag source depends on mode
	assign set_bits[INT_PERIOD] = pwm_mode ? pwm_evt : uf[0];
	// duty and third flags on underflow
	assign set_bits[INT_DUTY]   = uf[1];
	assign set_bits[INT_THIRD]  = uf[2];
	assign int_status_next = (int_status_reg & ~clr_bits) | set_bits;

	// Read mux; clear register reads zero
	wire [7:0] rd_misc = ({8{hit_watch}} & (watch_ctrl_reg & WCTL_MASK)) |
	                     ({8{hit_pwm}} & {5'h00, pwm_ctrl_reg}) |
	                     ({8{hit_stat}} & {5'h00, int_status_reg}) |
	                     ({8{hit_en}} & {5'h00, int_enable_reg});
	wire       mapped  = (|hit_ctrl) | (|hit_latch) | (|hit_cnt) | hit_watch |
	                     hit_pwm | hit_stat | hit_en | hit_clr;
	wire [DATA_W-1:0] rd_word = {24'h000000, rd_misc | rd_or[N_TIMERS]};

	// APB answer prepared in setup so access needs no wait
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready_reg  <= 1'b0;
			pslverr_reg <= 1'b0;
			prdata_reg  <= '0;
		end else begin
			pready_reg  <= setup;
			pslverr_reg <= setup & ~mapped;
			prdata_reg  <= (setup && !pwrite) ? rd_word : '0;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			watch_ctrl_reg <= WCTL_RESET;
			pwm_ctrl_reg   <= '0;
			int_enable_reg <= '0;
			int_status_reg <= '0;
		end else begin
			if (acc_wr && hit_watch) begin
				watch_ctrl_reg <= pwdata[7:0] & WCTL_MASK;
			end
			if (acc_wr && hit_pwm) begin
				pwm_ctrl_reg <= pwdata[2:0] & PWMC_MASK;
			end
			if (acc_wr && hit_en) begin
				int_enable_reg <= pwdata[INT_W-1:0];
			end
			int_status_reg <= int_status_next;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pin_prev_reg  <= 1'b0;
			osc_div_reg   <= 1'b0;
			instr_cnt_reg <= '0;
		end else begin
			pin_prev_reg <= shared_port_pin;
			osc_div_reg  <= ~osc_div_reg;
			if (osc_tick) begin
				instr_cnt_reg <= instr_tick ? 2'h0 : instr_cnt_reg + 2'h1;
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pwm_state_reg     <= RTP_PWM_IDLE;
			pulse_cnt_reg     <= '0;
			pulse_output_reg  <= 1'b0;
			irq_reg           <= 1'b0;
			shared_pin_io_reg <= 1'b0;
		end else begin
			pwm_state_reg     <= pwm_state_next;
			pulse_cnt_reg     <= pulse_cnt_next;
			pulse_output_reg  <= (pwm_state_next == RTP_PWM_HIGH);
			irq_reg           <= |(int_status_next & int_enable_reg);
			// pin is ordinary input when not selected
			shared_pin_io_reg <= ext_sel ? 1'b0 : shared_port_pin;
		end
	end

	assign pready        = pready_reg;
	assign pslverr       = pslverr_reg;
	assign prdata        = prdata_reg;
	assign pulse_output  = pulse_output_reg;
	assign irq           = irq_reg;
	assign shared_pin_io = shared_pin_io_reg;

	chk_flag_sticky: assert property (@(posedge pclk) disable iff (!presetn)
		int_status_reg[INT_DUTY] && !clr_bits[INT_DUTY] |=> int_status_reg[INT_DUTY])
		else $error("duty flag dropped without clear");
	chk_third_flag: assert property (@(posedge pclk) disable iff (!presetn)
		uf[2] |=> int_status_reg[INT_THIRD])
		else $error("third flag not set on underflow");
	chk_period_flag: assert property (@(posedge pclk) disable iff (!presetn)
		uf[0] && !pwm_mode |=> int_status_reg[INT_PERIOD])
		else $error("period flag not set on underflow");
	chk_pwm_start: assert property (@(posedge pclk) disable iff (!presetn)
		pwm_start |=> pulse_output ##1 (pulse_output || !$past(pwm_mode) || $past(uf[1])))
		else $error("pwm did not start high");
	chk_pwm_fall: assert property (@(posedge pclk) disable iff (!presetn)
		pwm_mode && pwm_state_reg == RTP_PWM_HIGH && uf[1] && !uf[0] |=> !pulse_output)
		else $error("pwm stayed high after duty zero");
	chk_pwm_rise: assert property (@(posedge pclk) disable iff (!presetn)
		pwm_mode && !pwm_start && uf[0] |=> pulse_output)
		else $error("pwm not high at period reload");
	chk_ext_gate: assert property (@(posedge pclk) disable iff (!presetn)
		!ext_sel |-> !ev_rise && !ev_fall)
		else $error("event edge seen with pin not selected");
	chk_t3_no_osc2: assert property (@(posedge pclk) disable iff (!presetn)
		ctrl_reg[2][CTRL_SRC_LSB+1:CTRL_SRC_LSB] == RTP_SRC_OSC2 |-> !tick[2])
		else $error("third timer ticked on doubled clock");
	chk_instr_rate: assert property (@(posedge pclk) disable iff (!presetn)
		instr_tick |=> !instr_tick [*3])
		else $error("instruction tick too frequent");
	chk_apb_ready: assert property (@(posedge pclk) disable iff (!presetn)
		setup |=> pready ##1 !pready)
		else $error("apb access not answered in one cycle");

	cov_pwm_fall: cover property (@(posedge pclk) disable iff (!presetn)
		pulse_output ##1 !pulse_output ##[1:600] pulse_output);
	cov_third_flag: cover property (@(posedge pclk) disable iff (!presetn) uf[2]);
	cov_irq_rise: cover property (@(posedge pclk) disable iff (!presetn) $rose(irq));
	cov_autoload: cover property (@(posedge pclk) disable iff (!presetn) |load_now);
endmodule

// ==== test/tb_rtp_reload_timers.sv ====
// Self-checking bench for the reload timers block
`timescale 1ns/1ns
module tb_rtp_reload_timers;
	import rtp_pkg::*;

	logic              pclk, presetn, psel, penable, pwrite;
	logic [ADDR_W-1:0] paddr;
	logic [DATA_W-1:0] pwdata, prdata, rd;
	logic              pready, pslverr, err;
	logic              shared_port_pin, osc_instr_div2, shared_pin_io, pulse_output, irq;
	int                n_fail, cmp_count, seed, cyc, pin_div, pin_cnt;

	rtp_reload_timers dut (
		.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
		.prdata(prdata), .pslverr(pslverr), .shared_port_pin(shared_port_pin),
		.osc_instr_div2(osc_instr_div2), .shared_pin_io(shared_pin_io),
		.pulse_output(pulse_output), .irq(irq)
	);

	initial pclk = 1'b0;
	always #5 pclk = ~pclk;

	// Free cycle count and event pin toggling every pin_div cycles
	always @(posedge pclk) begin
		cyc <= cyc + 1;
		if (pin_div != 0) begin
			pin_cnt <= (pin_cnt + 1 >= pin_div) ? 0 : pin_cnt + 1;
			if (pin_cnt + 1 >= pin_div)
				shared_port_pin <= ~shared_port_pin;
		end
	end

	task summarize;
		if (n_fail == 0 && cmp_count > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask

	task timeout;
		n_fail++;
		summarize;
	endtask

	task chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		cmp_count++;
		if (got !== exp) begin
			n_fail++;
			$display("Error %s expected %h seen %h", what, exp, got);
		end
	endtask

	task apb(input logic w, input logic [ADDR_W-1:0] a, input logic [7:0] d);
		int n;
		@(posedge pclk);
		psel    <= 1'b1;
		penable <= 1'b0;
		pwrite  <= w;
		paddr   <= a;
		pwdata  <= {24'h0, d};
		@(posedge pclk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 50);
		if (n >= 50)
			timeout;
		rd = prdata;
		err = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
	endtask

	function automatic logic [ADDR_W-1:0] ra(input logic [7:0] idx);
		return {2'b00, idx, 2'b00};
	endfunction

	// Control byte: run, source, edge, prescale, autoload
	function automatic logic [7:0] cfg(input int src, input int edg, input int ps, input int ld);
		return 8'(1 | (src << 1) | (edg << 3) | (ps << 4) | (ld << 7));
	endfunction

	task wr(input logic [7:0] idx, input logic [7:0] d);
		apb(1'b1, ra(idx), d);
	endtask

	task rdc(input string what, input logic [7:0] idx, input logic [7:0] exp);
		apb(1'b0, ra(idx), 8'h00);
		chk(what, {24'h0, exp}, rd);
	endtask

	// Bounded wait for irq (sel 0) or pulse output (sel 1)
	task wait_sig(input int sel, input logic lvl);
		int n;
		n = 0;
		while (((sel == 0) ? irq : pulse_output) !== lvl && n < 3000) begin
			@(posedge pclk);
			n++;
		end
		if (n >= 3000) begin
			$display("Error wait sel %0d expected %b seen x", sel, lvl);
			timeout;
		end
	endtask

	// First interval after a config change is discarded
	task measure(input int bitn, input int exp, input string what);
		int t0;
		wr(IDX_INT_ENABLE, 8'(1 << bitn));
		wr(IDX_INT_CLEAR, 8'h07);
		wait_sig(0, 1'b0);
		wait_sig(0, 1'b1);
		t0 = cyc;
		wr(IDX_INT_CLEAR, 8'h07);
		wait_sig(0, 1'b0);
		wait_sig(0, 1'b1);
		chk(what, 32'(exp), 32'(cyc - t0));
	endtask

	int          p, d, k, t0, t1;
	logic [7:0]  v;
	int          src_t[6]  = '{1, 1, 2, 0, 0, 2};
	int          edg_t[6]  = '{0, 0, 0, 0, 1, 0};
	int          ps_t[6]   = '{1, 0, 2, 0, 1, 7};
	int          div2_t[6] = '{1, 0, 0, 0, 0, 0};
	int          pdiv_t[6] = '{0, 0, 0, 3, 4, 0};
	int          mul_t[6]  = '{8, 8, 8, 6, 16, 256};

	initial begin
		{psel, penable, pwrite, paddr, pwdata} = '0;
		{shared_port_pin, osc_instr_div2} = 2'b00;
		presetn = 1'b0;
		{n_fail, cmp_count, cyc, pin_div, pin_cnt} = '0;
		seed = 47;
		repeat (20) @(posedge pclk);
		presetn <= 1'b1;
		for (int i = 0; i < 3; i++) begin
			rdc("ctrl reset", 8'(IDX_CTRL_BASE + i), 8'h00);
			rdc("count reset", 8'(IDX_COUNT_BASE + i), 8'h00);
		end
		// Pin high first, else the selected case cannot fail
		shared_port_pin <= 1'b1;
		wr(IDX_WATCH_CTRL, 8'hff);
		rdc("watch ctrl", IDX_WATCH_CTRL, WCTL_MASK);
		chk("pin io selected", 0, 32'(shared_pin_io));
		wr(IDX_WATCH_CTRL, 8'h00);
		repeat (3) @(posedge pclk);
		chk("pin io plain", 1, 32'(shared_pin_io));
		apb(1'b0, 12'h0c0, 8'h00);
		chk("unmapped err", 1, 32'(err));
		apb(1'b0, 12'h041, 8'h00);
		chk("misaligned err", 1, 32'(err));
		// Latch writes without autoload leave counts alone
		for (int i = 0; i < 3; i++) begin
			v = 8'($random(seed));
			wr(8'(IDX_LATCH_BASE + i), v);
			rdc("latch rw", 8'(IDX_LATCH_BASE + i), v);
			rdc("count no load", 8'(IDX_COUNT_BASE + i), 8'h00);
		end
		wr(IDX_CTRL_BASE + 8'h1, 8'h80);
		v = 8'($random(seed));
		wr(IDX_LATCH_BASE + 8'h1, v);
		rdc("count autoload", IDX_COUNT_BASE + 8'h1, v);
		repeat (50) @(posedge pclk);
		rdc("count frozen", IDX_COUNT_BASE + 8'h1, v);
		wr(IDX_CTRL_BASE + 8'h2, cfg(3, 0, 0, 1));
		wr(IDX_LATCH_BASE + 8'h2, 8'h05);
		repeat (100) @(posedge pclk);
		rdc("third no doubled", IDX_COUNT_BASE + 8'h2, 8'h05);
		// Third timer over every source it owns
		wr(IDX_WATCH_CTRL, 8'h10);
		for (int i = 0; i < 6; i++) begin
			p = 2 + ($unsigned($random(seed)) % 8);
			wr(IDX_CTRL_BASE + 8'h2, 8'h00);
			osc_instr_div2 <= div2_t[i][0];
			pin_div <= pdiv_t[i];
			wr(IDX_LATCH_BASE + 8'h2, 8'(p));
			wr(IDX_CTRL_BASE + 8'h2, cfg(src_t[i], edg_t[i], ps_t[i], 0));
			measure(INT_THIRD, (p + 1) * mul_t[i], "third period");
		end
		wr(IDX_CTRL_BASE + 8'h2, 8'h00);
		pin_div <= 0;
		rdc("third flag sticky", IDX_INT_STATUS, 8'h04);
		wr(IDX_INT_ENABLE, 8'h00);
		repeat (3) @(posedge pclk);
		chk("irq masked", 0, 32'(irq));
		wr(IDX_INT_CLEAR, 8'h04);
		rdc("status cleared", IDX_INT_STATUS, 8'h00);
		// Random PWM shapes, duty kept below period
		for (int i = 0; i < 4; i++) begin
			k = $unsigned($random(seed)) % 3;
			p = 3 + ($unsigned($random(seed)) % 30);
			d = $unsigned($random(seed)) % p;
			wr(IDX_PWM_CTRL, 8'h00);
			wr(IDX_CTRL_BASE, 8'h00);
			wr(IDX_CTRL_BASE + 8'h1, 8'h00);
			wr(IDX_LATCH_BASE, 8'(p));
			wr(IDX_LATCH_BASE + 8'h1, 8'(d));
			wr(IDX_CTRL_BASE + 8'h1, cfg(3, 0, k, 0));
			wr(IDX_CTRL_BASE, cfg(3, 0, k, 0));
			wr(IDX_PWM_CTRL, 8'h01);
			wait_sig(1, 1'b0);
			wait_sig(1, 1'b1);
			t0 = cyc;
			wait_sig(1, 1'b0);
			t1 = cyc;
			wait_sig(1, 1'b1);
			chk("pwm high", 32'((d + 1) << k), 32'(t1 - t0));
			chk("pwm period", 32'((p + 1) << k), 32'(cyc - t0));
		end
		apb(1'b0, ra(IDX_INT_STATUS), 8'h00);
		chk("duty flag", 1, 32'(rd[INT_DUTY]));
		wr(IDX_CTRL_BASE, 8'h00);
		wr(IDX_LATCH_BASE, 8'h0f);
		wr(IDX_CTRL_BASE, cfg(3, 0, 0, 0));
		for (int r = 0; r < 4; r++) begin
			wr(IDX_PWM_CTRL, 8'(1 | (r << 1)));
			measure(INT_PERIOD, (1 << r) * 16, "pwm rate");
		end
		wr(IDX_PWM_CTRL, 8'h00);
		repeat (4) @(posedge pclk);
		chk("pwm off low", 0, 32'(pulse_output));
		summarize;
	end
endmodule
